// file: verilog/flash_status_pkg.sv
package flash_status_pkg;
  // ****************************************
  // status bit positions
  // ****************************************
  localparam int unsigned DATA_POLLING_BIT        = 7;
  localparam int unsigned TOGGLE_STATUS_BIT       = 6;
  localparam int unsigned TIMEOUT_FAILURE_BIT     = 5;
  localparam int unsigned ERASE_START_BIT         = 3;
  localparam int unsigned ERASE_SECTOR_TOGGLE_BIT = 2;
  localparam int unsigned DATA_W                  = 8;
  localparam int unsigned ADDR_W                  = 22;

  // ****************************************
  // bus timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned READ_CYCLE_NS   = 90;
  localparam int unsigned READ_CYCLES     = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_PULSE_NS  = 50;
  localparam int unsigned WRITE_CYCLES    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W           = 8;

  // ****************************************
  // reset command
  // ****************************************
  localparam logic [DATA_W-1:0] RESET_CMD   = 8'hf0;
  localparam logic [ADDR_W-1:0] RESET_ADDR  = 22'h000000;

  // ****************************************
  // poll outcome codes
  // ****************************************
  typedef enum logic [1:0] {
    RES_NONE    = 2'h0,
    RES_OK      = 2'h1,
    RES_FAIL    = 2'h2
  } poll_result_t;
endpackage : flash_status_pkg

// file: verilog/flash_bus_cycle.sv
`timescale 1ns/100ps
// ****************************************
// one timed read or write strobe cycle
// ****************************************
module flash_bus_cycle
  import flash_status_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   start_i,
  input  wire logic                   write_i,
  input  wire logic [ADDR_W-1:0]      addr_i,
  input  wire logic [DATA_W-1:0]      wdata_i,
  input  wire logic [DATA_W-1:0]      dq_in_i,
  output logic                        done_o,
  output logic      [DATA_W-1:0]      rdata_o,
  output logic                        ce_n_o,
  output logic                        oe_n_o,
  output logic                        we_n_o,
  output logic      [ADDR_W-1:0]      addr_o,
  output logic      [DATA_W-1:0]      dq_out_o,
  output logic                        dq_oe_n_o
);
  import flash_status_pkg::*;

  typedef struct packed {
    logic              busy;
    logic              wr;
    logic [CNT_W-1:0]  cnt;
    logic              done;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
  } cyc_state_t;

  cyc_state_t st_reg;
  cyc_state_t st_next;

  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    st_next.s1   = dq_in_i;
    st_next.s2   = st_reg.s1;
    st_next.s3   = st_reg.s2;
    if (!st_reg.busy) begin
      if (start_i) begin
        st_next.busy  = 1'b1;
        st_next.wr    = write_i;
        st_next.addr  = addr_i;
        st_next.wdata = wdata_i;
        st_next.cnt   = write_i ? CNT_W'(WRITE_CYCLES) : CNT_W'(READ_CYCLES + 2);
      end
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - CNT_W'(1);
    end else if (st_reg.wr || (st_reg.s2 == st_reg.s3)) begin
      // strobe release ends the cycle; data counted once synchronisers agree
      st_next.busy  = 1'b0;
      st_next.done  = 1'b1;
      st_next.rdata = st_reg.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign done_o    = st_reg.done;
  assign rdata_o   = st_reg.rdata;
  assign ce_n_o    = ~st_reg.busy;
  assign oe_n_o    = ~(st_reg.busy & ~st_reg.wr);
  assign we_n_o    = ~(st_reg.busy & st_reg.wr);
  assign addr_o    = st_reg.addr;
  assign dq_out_o  = st_reg.wdata;
  assign dq_oe_n_o = ~(st_reg.busy & st_reg.wr);
endmodule : flash_bus_cycle

// file: verilog/flash_status_poller.sv
`timescale 1ns/100ps
// Operation
// - host reads full byte twice and compares toggle bit between reads
// - still toggling: test timeout bit; if high, repeat toggle check
// - toggling after timeout high means failure; issue reset command
// - host uses polling bit first, then toggle bit for success
module flash_status_poller
  import flash_status_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_i,
  input  wire logic                   poll_start_i,
  input  wire logic                   poll_erase_i,
  input  wire logic [ADDR_W-1:0]      poll_addr_i,
  input  wire logic [DATA_W-1:0]      poll_expect_i,
  output logic                        poll_busy_o,
  output logic                        poll_done_o,
  output logic                        poll_ok_o,
  output logic                        poll_fail_o,
  output logic                        poll_sector_err_o,
  output logic                        poll_erase_started_o,
  output logic      [DATA_W-1:0]      poll_data_o,
  output logic                        ce_n_o,
  output logic                        oe_n_o,
  output logic                        we_n_o,
  output logic      [ADDR_W-1:0]      addr_o,
  input  wire logic [DATA_W-1:0]      dq_in_i,
  output logic      [DATA_W-1:0]      dq_out_o,
  output logic                        dq_oe_n_o
);
  import flash_status_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_POLL    = 3'b001,
    ST_TOG_A   = 3'b011,
    ST_TOG_B   = 3'b010,
    ST_RECHK_A = 3'b110,
    ST_RECHK_B = 3'b111,
    ST_DATA    = 3'b101,
    ST_RESET   = 3'b100
  } poll_fsm_t;

  typedef struct packed {
    poll_fsm_t         fsm;
    logic              issued;
    logic              erase;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] expect_data;
    logic [DATA_W-1:0] first;
    logic              saw_timeout;
    logic              done;
    logic              ok;
    logic              fail;
    logic              sector_err;
    logic              erase_started;
    logic [DATA_W-1:0] data;
  } poll_state_t;

  poll_state_t st_reg;
  poll_state_t st_next;

  logic              cyc_start;
  logic              cyc_write;
  logic              cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic              toggled;
  logic              polled_done;

  // ****************************************
  // bus cycle engine
  // ****************************************
  flash_bus_cycle u_cycle (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .start_i   (cyc_start),
    .write_i   (cyc_write),
    .addr_i    (st_reg.fsm == ST_RESET ? RESET_ADDR : st_reg.addr),
    .wdata_i   (RESET_CMD),
    .dq_in_i   (dq_in_i),
    .done_o    (cyc_done),
    .rdata_o   (cyc_rdata),
    .ce_n_o    (ce_n_o),
    .oe_n_o    (oe_n_o),
    .we_n_o    (we_n_o),
    .addr_o    (addr_o),
    .dq_out_o  (dq_out_o),
    .dq_oe_n_o (dq_oe_n_o)
  );

  // one completed strobe cycle per read, device advances toggles on each
  assign toggled     = cyc_rdata[TOGGLE_STATUS_BIT] != st_reg.first[TOGGLE_STATUS_BIT];
  // erase completes at 1, program at true bit 7
  assign polled_done = st_reg.erase ? cyc_rdata[DATA_POLLING_BIT]
                     : (cyc_rdata[DATA_POLLING_BIT] == st_reg.expect_data[DATA_POLLING_BIT]);
  assign cyc_start   = (st_reg.fsm != ST_IDLE) && !st_reg.issued;
  assign cyc_write   = st_reg.fsm == ST_RESET;

  // ****************************************
  // polling sequence
  // ****************************************
  always_comb begin
    st_next      = st_reg;
    st_next.done = 1'b0;
    if (cyc_start) begin
      st_next.issued = 1'b1;
    end
    if (cyc_done) begin
      st_next.issued = 1'b0;
    end
    unique case (st_reg.fsm)
      ST_IDLE: begin
        if (poll_start_i) begin
          st_next.fsm         = ST_POLL;
          st_next.erase       = poll_erase_i;
          st_next.addr        = poll_addr_i;
          st_next.expect_data = poll_expect_i;
          st_next.saw_timeout = 1'b0;
          st_next.ok          = 1'b0;
          st_next.fail        = 1'b0;
          st_next.sector_err  = 1'b0;
        end
      end
      ST_POLL: begin
        if (cyc_done) begin
          st_next.erase_started = cyc_rdata[ERASE_START_BIT];
          // polling bit first, timeout bit only after that
          if (polled_done) begin
            st_next.fsm = ST_TOG_A;
          end else if (cyc_rdata[TIMEOUT_FAILURE_BIT]) begin
            st_next.fsm = ST_TOG_A;
          end
        end
      end
      ST_TOG_A: begin
        if (cyc_done) begin
          st_next.first = cyc_rdata;
          st_next.fsm   = ST_TOG_B;
        end
      end
      ST_TOG_B: begin
        if (cyc_done) begin
          if (!toggled) begin
            st_next.fsm = ST_DATA;
          end else if (cyc_rdata[TIMEOUT_FAILURE_BIT]) begin
            st_next.saw_timeout = 1'b1;
            // sector toggle with timeout high flags the addressed sector
            st_next.sector_err  = cyc_rdata[ERASE_SECTOR_TOGGLE_BIT]
                                != st_reg.first[ERASE_SECTOR_TOGGLE_BIT];
            st_next.fsm         = ST_RECHK_A;
          end else begin
            // still running, keep checking; protected sectors stop on their own
            st_next.fsm = ST_TOG_A;
          end
        end
      end
      ST_RECHK_A: begin
        if (cyc_done) begin
          st_next.first = cyc_rdata;
          st_next.fsm   = ST_RECHK_B;
        end
      end
      ST_RECHK_B: begin
        if (cyc_done) begin
          st_next.fsm = toggled ? ST_RESET : ST_DATA;
        end
      end
      ST_DATA: begin
        if (cyc_done) begin
          // bit 2 here is plain array data
          st_next.data = cyc_rdata;
          st_next.ok   = 1'b1;
          st_next.done = 1'b1;
          st_next.fsm  = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (cyc_done) begin
          st_next.fail = 1'b1;
          st_next.done = 1'b1;
          st_next.fsm  = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign poll_busy_o          = st_reg.fsm != ST_IDLE;
  assign poll_done_o          = st_reg.done;
  assign poll_ok_o            = st_reg.ok;
  assign poll_fail_o          = st_reg.fail;
  assign poll_sector_err_o    = st_reg.sector_err;
  assign poll_erase_started_o = st_reg.erase_started;
  assign poll_data_o          = st_reg.data;
endmodule : flash_status_poller

// file: tb/flash_status_props.sv
`timescale 1ns/100ps
// ****
// poller port checks
// ****
module flash_status_props
  import flash_status_pkg::*;
(
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              poll_start_i,
  input wire logic              poll_busy_o,
  input wire logic              poll_done_o,
  input wire logic              poll_ok_o,
  input wire logic              poll_fail_o,
  input wire logic              ce_n_o,
  input wire logic              oe_n_o,
  input wire logic              we_n_o,
  input wire logic [DATA_W-1:0] dq_out_o,
  input wire logic              dq_oe_n_o
);
  logic [7:0] reads_reg;
  logic       rst_wr_reg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  always_ff @(posedge clk_i) begin
    if (reset_i || (poll_start_i && !poll_busy_o)) begin
      reads_reg  <= 8'h00;
      rst_wr_reg <= 1'b0;
    end else begin
      if ($fell(oe_n_o)) reads_reg <= reads_reg + 8'h01;
      if (!we_n_o && !ce_n_o && !dq_oe_n_o && dq_out_o == RESET_CMD) rst_wr_reg <= 1'b1;
    end
  end
  sequence s_start; poll_start_i && !poll_busy_o; endsequence
  sequence s_ok; poll_done_o && poll_ok_o; endsequence
  property p_busy; s_start |=> poll_busy_o; endproperty
  property p_pulse; poll_done_o |=> !poll_done_o; endproperty
  property p_verdict; poll_done_o |-> (poll_ok_o ^ poll_fail_o); endproperty
  property p_pair; s_ok |-> reads_reg >= 8'h04; endproperty
  property p_recheck; poll_done_o && poll_fail_o |-> reads_reg >= 8'h05; endproperty
  property p_reset; $rose(poll_fail_o) |-> rst_wr_reg; endproperty
  property p_no_reset; s_ok |-> !rst_wr_reg; endproperty
  property p_no_clash; !dq_oe_n_o |-> oe_n_o; endproperty
  property p_hold; $fell(oe_n_o) |-> (!oe_n_o && !ce_n_o) [*8]; endproperty
  a_busy: assert property (p_busy) else $error("busy missing after start");
  a_pulse: assert property (p_pulse) else $error("done longer than one cycle");
  a_verdict: assert property (p_verdict) else $error("done without one verdict");
  a_pair: assert property (p_pair) else $error("ok before toggle pair and data read");
  a_recheck: assert property (p_recheck) else $error("fail without recheck pair");
  a_reset: assert property (p_reset) else $error("fail without reset write");
  a_no_reset: assert property (p_no_reset) else $error("ok after reset write");
  a_no_clash: assert property (p_no_clash) else $error("host drives during read");
  a_hold: assert property (p_hold) else $error("read strobe too short");
endmodule : flash_status_props

bind flash_status_poller flash_status_props u_props (
  .clk_i(clk_i), .reset_i(reset_i), .poll_start_i(poll_start_i), .poll_busy_o(poll_busy_o),
  .poll_done_o(poll_done_o), .poll_ok_o(poll_ok_o), .poll_fail_o(poll_fail_o),
  .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .dq_out_o(dq_out_o),
  .dq_oe_n_o(dq_oe_n_o));

// file: tb/flash_dev_model.sv
`timescale 1ns/100ps
// ****
// status side of the flash device
// ****
module flash_dev_model (
  input  wire logic       ce_n_i,
  input  wire logic       oe_n_i,
  input  wire logic       we_n_i,
  input  wire logic [7:0] host_dq_i,
  input  wire logic       host_oe_n_i,
  input  wire logic       arm_i,
  input  wire logic       erase_i,
  input  wire logic       dq5_i,
  input  wire logic       stuck_i,
  input  wire logic [7:0] busy_reads_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] bus_o,
  output logic            reset_seen_o
);
  logic [7:0] cnt;
  logic [7:0] held;
  logic [7:0] stat;
  logic       t6;
  logic       in_rd;
  logic       busy;
  // toggle window of busy_reads_i reads, or until the reset write when stuck_i, then data unchanged
  assign busy = (cnt < busy_reads_i) || (stuck_i && !reset_seen_o);
  always_comb begin
    stat = data_i;
    if (busy) begin
      stat[7] = erase_i ? 1'b0 : ~data_i[7];
      stat[6] = t6;
      stat[5] = dq5_i;
      stat[3] = erase_i | data_i[3];
      if (erase_i) stat[2] = t6;
    end
  end
  // released bus shows the inverse of the last value
  assign bus_o = (!ce_n_i && !oe_n_i) ? stat : (!host_oe_n_i ? host_dq_i : ~held);
  always @(arm_i or ce_n_i or oe_n_i or we_n_i or host_dq_i or host_oe_n_i) begin
    if (arm_i) begin
      cnt = 8'h00;
      t6 = 1'b0;
      held = 8'h00;
      in_rd = 1'b0;
      reset_seen_o = 1'b0;
    end else if (!ce_n_i && !oe_n_i) begin
      in_rd = 1'b1;
    end else if (in_rd) begin
      in_rd = 1'b0;
      held = stat;
      if (busy) begin
        cnt = cnt + 8'h01;
        t6 = ~t6;
      end
    end
    if (!ce_n_i && !we_n_i && !host_oe_n_i && host_dq_i == 8'hf0) reset_seen_o = 1'b1;
  end
endmodule : flash_dev_model

// file: tb/tb.sv
`timescale 1ns/100ps
// ****
// poller testbench
// ****
module tb;
  import flash_status_pkg::*;
  logic              clk_i = 1'b0;
  logic              reset_i, start, erase, arm, dq5, stuck, busy, done, ok, fail, serr, estart;
  logic              ce_n, oe_n, we_n, dq_oe_n, rseen;
  logic [ADDR_W-1:0] addr, a_out;
  logic [7:0]        expect_d, busy_reads, data, pdata, bus, dq_out;
  int                mismatches, checks_done;
  always #5 clk_i = ~clk_i;
  flash_status_poller DUT (.clk_i(clk_i), .reset_i(reset_i), .poll_start_i(start),
    .poll_erase_i(erase), .poll_addr_i(addr), .poll_expect_i(expect_d), .poll_busy_o(busy),
    .poll_done_o(done), .poll_ok_o(ok), .poll_fail_o(fail), .poll_sector_err_o(serr),
    .poll_erase_started_o(estart), .poll_data_o(pdata), .ce_n_o(ce_n), .oe_n_o(oe_n),
    .we_n_o(we_n), .addr_o(a_out), .dq_in_i(bus), .dq_out_o(dq_out), .dq_oe_n_o(dq_oe_n));
  flash_dev_model dev (.ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n), .host_dq_i(dq_out),
    .host_oe_n_i(dq_oe_n), .arm_i(arm), .erase_i(erase), .dq5_i(dq5), .stuck_i(stuck),
    .busy_reads_i(busy_reads), .data_i(data), .bus_o(bus), .reset_seen_o(rseen));
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  task run_poll(input logic er, d5, stk, input logic [7:0] nb, dat, input logic exp_ok);
    int n;
    @(posedge clk_i);
    {erase, dq5, stuck, busy_reads, data, expect_d} <= {er, d5, stk, nb, dat, dat};
    addr <= addr + 22'h000001;
    arm <= 1'b1;
    start <= 1'b1;
    @(posedge clk_i);
    arm <= 1'b0;
    start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 20000) begin
      mismatches++;
      $display("ERROR done expected 1 seen %b", done);
      tally_and_finish();
    end
    chk("ok", 8'(exp_ok), 8'(ok));
    chk("fail", 8'(!exp_ok), 8'(fail));
    chk("reset_write", 8'(!exp_ok), 8'(rseen));
    chk("erase_started", 8'(er), 8'(estart));
    chk("sector_err", 8'(!exp_ok && er), 8'(serr));
    if (exp_ok) chk("data", dat, pdata);
    checks_done++;
    // last cycle is the data read on success, the reset write on failure
    if (a_out !== (exp_ok ? addr : RESET_ADDR)) begin
      mismatches++;
      $display("ERROR addr_o expected %h seen %h", (exp_ok ? addr : RESET_ADDR), a_out);
    end
  endtask : run_poll
  initial begin
    // arm starts low so the first arm pulse is an edge the model sees
    {reset_i, start, erase, arm, dq5, stuck} = 6'b100000;
    {busy_reads, data, expect_d} = 24'h000000;
    addr = 22'h000100;
    mismatches = 0;
    checks_done = 0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    run_poll(1'b0, 1'b0, 1'b0, 8'h03, 8'ha5, 1'b1);
    run_poll(1'b1, 1'b0, 1'b0, 8'h04, 8'hff, 1'b1);
    run_poll(1'b0, 1'b1, 1'b0, 8'h02, 8'ha5, 1'b1);
    run_poll(1'b0, 1'b1, 1'b1, 8'h00, 8'ha5, 1'b0);
    run_poll(1'b1, 1'b1, 1'b1, 8'h00, 8'hff, 1'b0);
    run_poll(1'b0, 1'b0, 1'b0, 8'h00, 8'h42, 1'b1);
    tally_and_finish();
  end
endmodule : tb
